// ===== hw/eep_target.sv
// Function
// - Device word must carry fixed 1010 prefix
// - 2K compares all three select bits
// - 4K compares upper two, third is page
// - 8K compares top bit, two page bits
// - 16K compares none, three page bits
// - Last device bit picks read or write
// - Match acknowledges low, mismatch returns standby
// - Byte write: word address, data, both acknowledged
// - Programming after stop ignores the bus
// - Programming time counted from the stop
// - Page is 8 or 16 bytes
// - Page write acknowledges every further data byte
// - Write increments only low bits, wraps page
// - Poll acknowledged only after programming ends
// - Address counter keeps last access plus one
// - Read address wraps across whole memory
// - Current read sends byte at counter
// - Host ack continues read, nack ends it
// - Eight bit words, ack on ninth clock
// - Data falling with clock high is start
// - Data rising with clock high is stop
// - Data changes only while clock low
`timescale 1ns/1ps
`default_nettype none

module eep_target
	import eep_pkg::*;
#(
	parameter logic [1:0] DENSITY   = DENS_2K,
	parameter int         WR_CYCLES = T_WR_NS / CLK_PERIOD_NS
) (
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	input  wire logic select_pin_high_in,
	input  wire logic select_pin_mid_in,
	input  wire logic select_pin_low_in,
	output logic      sda_out,
	output logic      sda_oe_out,
	output logic      busy_out
);

	localparam logic [2:0]        SEL_CMP  = SEL_CMP_TBL[DENSITY];
	localparam logic [10:0]       PG_MASK  = PG_MASK_TBL[DENSITY];
	localparam logic [10:0]       PIDX_M   = PIDX_TBL[DENSITY];
	localparam logic [10:0]       AMASK    = WORD_MASK | PG_MASK;
	localparam logic [4:0]        PAGE_N   = PAGE_N_TBL[DENSITY];
	localparam logic [TMR_W-1:0]  TMR_LAST = TMR_W'(WR_CYCLES - 1);

	eep_state_t        r;
	eep_state_t        n;
	logic [BYTE_W-1:0] rdata;
	logic              scl;
	logic              sda;
	logic [2:0]        straps;
	logic              scl_rise;
	logic              scl_fall;
	logic              start;
	logic              stop;
	logic              dev_match;
	logic              byte_end;

	eep_mem eep_mem_i (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.wr_in     (r.wr),
		.raddr_in  (r.addr),
		.rdata_out (rdata)
	);

	always_comb begin
		n          = r;
		n.s1       = {select_pin_high_in, select_pin_mid_in, select_pin_low_in, sda_in, scl_in};
		n.s2       = r.s1;
		scl        = r.s2[0];
		sda        = r.s2[1];
		straps     = r.s2[4:2];
		n.scl_p    = scl;
		n.sda_p    = sda;
		n.wr.we    = 1'b0;
		scl_rise   = scl & ~r.scl_p;
		scl_fall   = ~scl & r.scl_p;
		// Data moving while clock stays high marks start or stop
		start      = scl & r.scl_p & r.sda_p & ~sda;
		stop       = scl & r.scl_p & ~r.sda_p & sda;
		dev_match  = (r.sh[7:4] == DEV_PREFIX) &&
			(((r.sh[3:1] ^ straps) & SEL_CMP) == '0);
		byte_end   = scl_fall && (r.bcnt == LAST_BIT);

		if (r.st == EEP_PROG) begin
			// Bus is ignored entirely, so polls get no ack here
			n.oe  = 1'b0;
			n.tmr = r.tmr + TMR_STEP;
			if (r.cidx < PAGE_N) begin
				n.wr.we   = r.pval[r.cidx[3:0]];
				n.wr.addr = r.wbase | ADDR_W'(r.cidx[3:0]);
				n.wr.data = r.pbuf[r.cidx[3:0]];
				n.cidx    = r.cidx + CIDX_STEP;
			end
			if (r.tmr == TMR_LAST) begin
				n.st   = EEP_IDLE;
				n.busy = 1'b0;
				n.pval = '0;
			end
		end else if (start) begin
			// A fresh start drops anything half done, buffer included
			n.st   = EEP_DEV;
			// The clock fall that closes the start is not a data bit
			n.bcnt = '1;
			n.oe   = 1'b0;
			n.pval = '0;
		end else if (stop) begin
			n.oe = 1'b0;
			if (r.st == EEP_WDATA && r.bcnt == '0 && |r.pval) begin
				n.st   = EEP_PROG;
				n.busy = 1'b1;
				n.cidx = '0;
				n.tmr  = '0;
			end else begin
				n.st   = EEP_IDLE;
				n.pval = '0;
			end
		end else if (r.st != EEP_IDLE) begin
			if (scl_rise) begin
				// Sampled only while clock high
				if (r.bcnt < ACK_BIT) begin
					n.sh = {r.sh[6:0], sda};
				end else begin
					n.hack = ~sda;
				end
			end
			if (scl_fall) begin
				if (r.bcnt == ACK_BIT) begin
					n.bcnt = '0;
					n.oe   = 1'b0;
					if (r.st == EEP_READ) begin
						if (r.hack) begin
							n.tx   = rdata;
							n.oe   = ~rdata[7];
							n.addr = (r.addr + ADDR_STEP) & AMASK;
						end else begin
							n.st = EEP_IDLE;
						end
					end
				end else if (r.bcnt == LAST_BIT) begin
					n.bcnt = ACK_BIT;
					unique case (r.st)
						EEP_DEV: begin
							if (dev_match) begin
								n.oe   = 1'b1;
								n.addr = (r.addr & ~PG_MASK) | ({r.sh[3:1], 8'h00} & PG_MASK);
								if (r.sh[0]) begin
									n.st   = EEP_READ;
									n.hack = 1'b1;
								end else begin
									n.st = EEP_WADDR;
								end
							end else begin
								n.st = EEP_IDLE;
							end
						end
						EEP_WADDR: begin
							n.oe    = 1'b1;
							n.addr  = (r.addr & PG_MASK) | ADDR_W'(r.sh);
							n.wbase = ((r.addr & PG_MASK) | ADDR_W'(r.sh)) & ~PIDX_M;
							n.st    = EEP_WDATA;
						end
						EEP_WDATA: begin
							// Full buffer keeps taking bytes; later ones overwrite
							n.oe = 1'b1;
							n.pbuf[r.addr[3:0] & PIDX_M[3:0]] = r.sh;
							n.pval[r.addr[3:0] & PIDX_M[3:0]] = 1'b1;
							n.addr = (r.addr & ~PIDX_M) | ((r.addr + ADDR_STEP) & PIDX_M);
						end
						EEP_READ: begin
							n.oe = 1'b0;
						end
						default: begin
							n.st = EEP_IDLE;
						end
					endcase
				end else begin
					n.bcnt = r.bcnt + 4'h1;
					if (r.st == EEP_READ) begin
						// Next bit goes out just after the falling edge
						n.tx = {r.tx[6:0], 1'b0};
						n.oe = ~r.tx[6];
					end else begin
						n.oe = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r       <= '0;
			r.st    <= EEP_IDLE;
			r.s1    <= 5'h03;
			r.s2    <= 5'h03;
			r.scl_p <= 1'b1;
			r.sda_p <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out    = r.wr.we & 1'b0;
	assign sda_oe_out = r.oe;
	assign busy_out   = r.busy;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_dev_done;
		r.st == EEP_DEV && byte_end && r.st != EEP_PROG && !start && !stop;
	endsequence

	sequence s_write_stop;
		stop && r.st == EEP_WDATA && r.bcnt == '0 && |r.pval;
	endsequence

	sequence s_read_load;
		r.st == EEP_READ && scl_fall && r.bcnt == ACK_BIT && r.hack && !start && !stop;
	endsequence

	a_prefix_reject: assert property (
		s_dev_done ##0 (r.sh[7:4] != DEV_PREFIX) |=> r.st == EEP_IDLE && !r.oe)
		else $error("bad prefix was not rejected");

	a_select_cmp: assert property (
		s_dev_done ##0 (((r.sh[3:1] ^ straps) & SEL_CMP) != '0) |=> r.st == EEP_IDLE)
		else $error("select mismatch was accepted");

	a_dev_ack: assert property (
		s_dev_done ##0 dev_match |=> r.oe && r.bcnt == ACK_BIT)
		else $error("matched device word not acknowledged");

	a_rw_select: assert property (
		s_dev_done ##0 dev_match |=> r.st == ($past(r.sh[0]) ? EEP_READ : EEP_WADDR))
		else $error("direction bit ignored");

	a_prog_silent: assert property (
		r.st == EEP_PROG |=> !r.oe)
		else $error("bus driven during programming");

	a_prog_length: assert property (
		s_write_stop |=> r.busy ##0 (r.tmr == '0))
		else $error("programming not started by stop");

	a_prog_end: assert property (
		r.st == EEP_PROG && r.tmr == TMR_LAST |=> r.st == EEP_IDLE && !r.busy)
		else $error("programming length wrong");

	a_commit_stop: assert property (
		s_write_stop ##1 r.st == EEP_PROG |-> ##[1:17] r.wr.we)
		else $error("buffered byte not committed");

	a_no_stray_wr: assert property (
		r.st != EEP_PROG |=> !r.wr.we)
		else $error("array written outside programming");

	a_page_wrap: assert property (
		r.st == EEP_WDATA && byte_end && !start && !stop
		|=> (r.addr & ~PIDX_M) == ($past(r.addr) & ~PIDX_M))
		else $error("write crossed page boundary");

	a_read_wrap: assert property (
		s_read_load |=> r.addr == (($past(r.addr) + ADDR_STEP) & AMASK) && r.oe == !r.tx[7])
		else $error("read address step wrong");

	a_start_abort: assert property (
		start && r.st != EEP_PROG |=> r.st == EEP_DEV && r.bcnt == '1 && r.pval == '0)
		else $error("start did not restart transaction");

	a_start_skip: assert property (
		r.st == EEP_DEV && r.bcnt == '1 && scl_fall && !start && !stop |=> r.bcnt == '0)
		else $error("start clock edge counted as a bit");

	a_ack_release: assert property (
		r.st inside {EEP_WADDR, EEP_WDATA} && scl_fall && r.bcnt == ACK_BIT && !start && !stop
		|=> !r.oe && r.bcnt == '0)
		else $error("acknowledge held past ninth clock");

	a_page_size: assert property (
		r.st == EEP_WDATA && byte_end && !start && !stop
		|=> $countones(r.pval) <= PAGE_N && r.oe)
		else $error("page buffer exceeded page size");

	a_stop_idle: assert property (
		stop && r.st != EEP_PROG && !(r.st == EEP_WDATA && r.bcnt == '0 && |r.pval)
		|=> r.st == EEP_IDLE && !r.oe && r.pval == '0)
		else $error("stop did not return to standby");

endmodule

`default_nettype wire

// ===== hw/eep_pkg.sv
package eep_pkg;

	localparam int          ADDR_W        = 11;
	localparam int          BYTE_W        = 8;
	localparam int          MEM_DEPTH     = 2048;
	localparam int          PAGE_MAX      = 16;
	localparam int          TMR_W         = 18;
	localparam logic [3:0]  DEV_PREFIX    = 4'hA;
	localparam logic [3:0]  LAST_BIT      = 4'h7;
	localparam logic [3:0]  ACK_BIT       = 4'h8;
	localparam logic [4:0]  CIDX_STEP     = 5'h01;
	localparam logic [10:0] ADDR_STEP     = 11'h001;
	localparam logic [10:0] WORD_MASK     = 11'h0FF;
	localparam logic [TMR_W-1:0] TMR_STEP = 18'h00001;

	// Densities
	localparam logic [1:0]  DENS_2K       = 2'h0;
	localparam logic [1:0]  DENS_4K       = 2'h1;
	localparam logic [1:0]  DENS_8K       = 2'h2;
	localparam logic [1:0]  DENS_16K      = 2'h3;

	// Per density tables, indexed by density code
	localparam logic [3:0][2:0]  SEL_CMP_TBL  = {3'h0, 3'h4, 3'h6, 3'h7};
	localparam logic [3:0][10:0] PG_MASK_TBL  = {11'h700, 11'h300, 11'h100, 11'h000};
	localparam logic [3:0][10:0] PIDX_TBL     = {11'h00F, 11'h00F, 11'h00F, 11'h007};
	localparam logic [3:0][4:0]  PAGE_N_TBL   = {5'h10, 5'h10, 5'h10, 5'h08};

	// Timing
	localparam int          CLK_PERIOD_NS = 25;
	localparam int          T_WR_NS       = 5000000;

	typedef enum logic [2:0] {
		EEP_IDLE,
		EEP_DEV,
		EEP_WADDR,
		EEP_WDATA,
		EEP_READ,
		EEP_PROG
	} eep_st_t;

	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [BYTE_W-1:0] data;
	} eep_wr_t;

	typedef struct packed {
		logic [4:0]                   s1;
		logic [4:0]                   s2;
		logic                         scl_p;
		logic                         sda_p;
		eep_st_t                      st;
		logic [3:0]                   bcnt;
		logic [BYTE_W-1:0]            sh;
		logic [BYTE_W-1:0]            tx;
		logic                         hack;
		logic                         oe;
		logic                         busy;
		logic [ADDR_W-1:0]            addr;
		logic [ADDR_W-1:0]            wbase;
		logic [PAGE_MAX-1:0][BYTE_W-1:0] pbuf;
		logic [PAGE_MAX-1:0]          pval;
		logic [4:0]                   cidx;
		logic [TMR_W-1:0]             tmr;
		eep_wr_t                      wr;
	} eep_state_t;

endpackage

// ===== hw/eep_mem.sv
`timescale 1ns/1ps
`default_nettype none

module eep_mem
	import eep_pkg::*;
#(
	parameter int DEPTH = MEM_DEPTH
) (
	input  wire logic              clk_in,
	input  wire logic              arst_n_in,
	input  wire eep_wr_t           wr_in,
	input  wire logic [ADDR_W-1:0] raddr_in,
	output logic      [BYTE_W-1:0] rdata_out
);

	logic [BYTE_W-1:0] mem_ff [DEPTH];
	logic [BYTE_W-1:0] rdata_ff;

	// Array has no reset: contents survive a protocol reset
	always_ff @(posedge clk_in) begin
		if (wr_in.we) begin
			mem_ff[wr_in.addr] <= wr_in.data;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= mem_ff[raddr_in];
		end
	end

	assign rdata_out = rdata_ff;

endmodule

`default_nettype wire

// ===== sim/eep_host.sv
`timescale 1ns/1ps
`default_nettype none

module eep_host (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out
);
	// Clock stands high between frames; released data is pulled up
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic bit_x(input logic b, output logic r);
		sda_out = b;
		hold(2);
		scl_out = 1'b1;
		hold(2);
		r = sda_in;
		hold(2);
		scl_out = 1'b0;
		hold(2);
	endtask
	task automatic start();
		sda_out = 1'b1;
		hold(2);
		scl_out = 1'b1;
		hold(4);
		sda_out = 1'b0;
		hold(4);
		scl_out = 1'b0;
		hold(2);
	endtask
	task automatic stop();
		sda_out = 1'b0;
		hold(2);
		scl_out = 1'b1;
		hold(4);
		sda_out = 1'b1;
		hold(4);
	endtask
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
		bit_x(a, k);
	endtask
endmodule

`default_nettype wire

// ===== sim/tb_eep_target.sv
`timescale 1ns/1ps
`default_nettype none

module tb_eep_target;
	import eep_pkg::*;
	// Long enough that the first poll lands inside programming
	localparam int WR = 400;
	logic       clk_in = 1'b0;
	logic       arst_n_in = 1'b0;
	logic       scl, sda_h, sda, sda_o, sda_oe, busy, ak;
	logic [7:0] q;
	int         fails = 0;
	int         tests_run = 0;
	int         busy_cnt = 0;
	always #12.5 clk_in = ~clk_in;
	assign sda = (sda_oe ? sda_o : 1'b1) & sda_h;
	always @(posedge clk_in) if (busy === 1'b1) busy_cnt++;
	eep_target #(.DENSITY(DENS_4K), .WR_CYCLES(WR)) eep_target_i (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .scl_in(scl), .sda_in(sda),
		.select_pin_high_in(1'b1), .select_pin_mid_in(1'b0), .select_pin_low_in(1'b1),
		.sda_out(sda_o), .sda_oe_out(sda_oe), .busy_out(busy));
	eep_host eep_host_i (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_out(sda_h));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	function automatic logic [7:0] dev(input logic p, input logic rw);
		return {DEV_PREFIX, 2'b10, p, rw};
	endfunction
	task automatic write_seq(input logic p, input logic [7:0] a, input int n, input logic [7:0] d0);
		int c0;
		c0 = busy_cnt;
		eep_host_i.start();
		eep_host_i.xfer(dev(p, 1'b0), 1'b1, q, ak);
		check(ak, 1'b0);
		eep_host_i.xfer(a, 1'b1, q, ak);
		check(ak, 1'b0);
		for (int i = 0; i < n; i++) begin
			eep_host_i.xfer(d0 + 8'(i), 1'b1, q, ak);
			check(ak, 1'b0);
		end
		eep_host_i.stop();
		eep_host_i.hold(6);
		check(busy, 1'b1);
		eep_host_i.start();
		eep_host_i.xfer(dev(p, 1'b0), 1'b1, q, ak);
		check(ak, 1'b1);
		for (int k = 0; k < 20 && ak !== 1'b0; k++) begin
			eep_host_i.start();
			eep_host_i.xfer(dev(p, 1'b0), 1'b1, q, ak);
		end
		check(ak, 1'b0);
		eep_host_i.stop();
		check(busy_cnt - c0, WR);
	endtask
	task automatic read_seq(input logic p, input logic rnd, input logic [7:0] a, input logic [7:0] e[$]);
		eep_host_i.start();
		if (rnd) begin
			eep_host_i.xfer(dev(p, 1'b0), 1'b1, q, ak);
			eep_host_i.xfer(a, 1'b1, q, ak);
			check(ak, 1'b0);
			eep_host_i.start();
		end
		eep_host_i.xfer(dev(p, 1'b1), 1'b1, q, ak);
		check(ak, 1'b0);
		foreach (e[i]) begin
			eep_host_i.xfer(8'hFF, i == e.size() - 1, q, ak);
			check(q, e[i]);
		end
		eep_host_i.stop();
	endtask
	task automatic t_refuse();
		logic [7:0] w[4] = '{8'hAC, 8'hA0, 8'hE8, 8'h28};
		foreach (w[i]) begin
			eep_host_i.start();
			eep_host_i.xfer(w[i], 1'b1, q, ak);
			check(ak, 1'b1);
			eep_host_i.stop();
		end
		$display("refuse finished");
	endtask
	task automatic t_page();
		logic [7:0] e[$];
		write_seq(1'b1, 8'h05, 17, 8'h30);
		read_seq(1'b1, 1'b0, 8'h00, '{8'h31, 8'h32, 8'h33});
		for (int a = 0; a < 16; a++) e.push_back(a == 5 ? 8'h40 : 8'h30 + 8'((a + 11) & 15));
		read_seq(1'b1, 1'b1, 8'h00, e);
		$display("page finished");
	endtask
	task automatic t_abort();
		eep_host_i.start();
		eep_host_i.xfer(dev(1'b1, 1'b0), 1'b1, q, ak);
		eep_host_i.xfer(8'h03, 1'b1, q, ak);
		for (int i = 0; i < 4; i++) eep_host_i.bit_x(1'b0, ak);
		eep_host_i.stop();
		eep_host_i.hold(10);
		check(busy, 1'b0);
		read_seq(1'b1, 1'b1, 8'h03, '{8'h3E});
		$display("abort finished");
	endtask
	task automatic t_wrap();
		write_seq(1'b1, 8'hFF, 1, 8'h5A);
		write_seq(1'b0, 8'h00, 1, 8'hA5);
		read_seq(1'b1, 1'b1, 8'hFF, '{8'h5A, 8'hA5});
		$display("wrap finished");
	endtask
	initial begin
		#(60000 * 25);
		fails++;
		stop_test();
	end
	initial begin
		repeat (20) @(negedge clk_in);
		check(sda_oe, 1'b0);
		check(busy, 1'b0);
		arst_n_in = 1'b1;
		repeat (6) @(negedge clk_in);
		t_refuse();
		t_page();
		t_abort();
		t_wrap();
		stop_test();
	end
endmodule

`default_nettype wire
